/* lichg_regs.vh */
// constants for the li-ion charge control block
`ifndef LICHG_REGS_VH
`define LICHG_REGS_VH
// status pin encoding: bit1 = status_a on, bit0 = status_b on
`define LICHG_STAT_PRE      2'h3
`define LICHG_STAT_FAST     2'h2
`define LICHG_STAT_DONE     2'h1
`define LICHG_STAT_OFF      2'h0
// filter length for synchronised inputs, in clock cycles
`define LICHG_FILT_CYC      4'h4
// clock period in ns
`define LICHG_CLK_NS        10
// termination detect and deglitch times, in us
`define LICHG_TRMDET_US     1000
`define LICHG_DEGL_US       1000
// safety timers, in ms
`define LICHG_PRECHG_MS     1000
`define LICHG_CHG_MS        10000
// derived cycle counts
`define LICHG_TRMDET_CYC  ((`LICHG_TRMDET_US * 1000) / `LICHG_CLK_NS)
`define LICHG_DEGL_CYC    ((`LICHG_DEGL_US * 1000) / `LICHG_CLK_NS)
`define LICHG_PRECHG_CYC  ((`LICHG_PRECHG_MS * 1000000) / `LICHG_CLK_NS)
`define LICHG_CHG_CYC     ((`LICHG_CHG_MS * 1000000) / `LICHG_CLK_NS)
`endif

/* lichg_sync_filt.v */
// two-flop synchroniser with a stability filter for one input
`timescale 1ns/1ps
`include "lichg_regs.vh"
module lichg_sync_filt #(
    parameter                RST_VAL = 1'b0
) (
    // clock and reset
    input  wire              i_ref_clk,
    input  wire              i_rst_n,
    input  wire              i_ce,
    // raw input and filtered output
    input  wire              i_async,
    output reg               o_level
);
    reg        meta_q;   // first stage, read only by sync_q
    reg        sync_q;   // second stage
    reg [3:0]  cnt_q;    // cycles the synced value differed from output

    ////////////////////////////////////////////////////////////////////
    // synchronise, then accept a change only after it held long enough
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q  <= RST_VAL;
            sync_q  <= RST_VAL;
            cnt_q   <= 4'h0;
            o_level <= RST_VAL;
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
            if (sync_q == o_level) begin
                cnt_q <= 4'h0;                 // glitch dropped
            end else if (cnt_q == `LICHG_FILT_CYC - 4'h1) begin
                o_level <= sync_q;
                cnt_q   <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

/* lichg_ctrl.v */
// charger state machine, status pins and regulator low-voltage latches
//
// Contract
// - end charge when current reaches termination level
// - restart charge when battery drops below recharge
// - status pins encode precharge, fast, done, off
// - regulation shows as fast; fault releases both status pins
// - charge_disable_n high halts all charging
// - fault above recharge held until battery falls
// - reset or disable toggle clears timer fault
// - fault below recharge enables probe current
// - undervoltage opens battery path into device
// - host re-enables charging from undervoltage cut-off
// - undervoltage restart begins in preconditioning
// - thermal limit turns charger, paths, regulators off
// - timers keep counting through thermal shutdown
// - no battery: regulate, stop, deglitch, repeat
// - low main output latches that output off
// - main latch kills group; enable toggle recovers
// - aux low-voltage latch; enable toggle recovers
`timescale 1ns/1ps
`include "lichg_regs.vh"
module lichg_ctrl #(
    parameter                TRMDET_CYC = `LICHG_TRMDET_CYC,
    parameter                DEGL_CYC   = `LICHG_DEGL_CYC,
    parameter                PRECHG_CYC = `LICHG_PRECHG_CYC,
    parameter                CHG_CYC    = `LICHG_CHG_CYC
) (
    // clock, reset, enable
    input  wire              i_ref_clk,
    input  wire              i_rst_n,
    input  wire              i_ce,
    // host controls (pins)
    input  wire              i_charge_disable_n,
    input  wire              i_main_rails_enable,
    input  wire              i_aux_rail_enable,
    // analog comparator events
    input  wire              i_input_good,
    input  wire              i_bat_below_lowv,
    input  wire              i_bat_at_reg,
    input  wire              i_bat_below_rch,
    input  wire              i_bat_below_uvlo,
    input  wire              i_term_current,
    input  wire              i_thermal_limit,
    input  wire [2:0]        i_main_low_voltage,
    input  wire              i_aux_low_voltage,
    // open-drain status pins (low only, enables drive)
    output wire              o_charge_status_a_o,
    output reg               o_charge_status_a_oe,
    output wire              o_charge_status_b_o,
    output reg               o_charge_status_b_oe,
    // charger and power control
    output reg               o_charger_on,
    output reg               o_precharge_mode,
    output reg               o_fault_probe_current,
    output reg               o_battery_path_on,
    output reg               o_power_paths_on,
    output reg               o_main_rails_on,
    output reg [2:0]         o_main_rail_latched,
    output reg               o_aux_rail_on,
    output reg [5:0]         o_charge_state
);
    // one-hot charger states
    localparam [5:0] ST_PRE  = 6'h01;  // preconditioning
    localparam [5:0] ST_FAST = 6'h02;  // fast charge, constant current
    localparam [5:0] ST_VREG = 6'h04;  // voltage regulation
    localparam [5:0] ST_DONE = 6'h08;  // terminated
    localparam [5:0] ST_SUSP = 6'h10;  // charger off
    localparam [5:0] ST_FLT  = 6'h20;  // safety timer fault

    // open-drain pins only ever pull low
    assign o_charge_status_a_o = 1'b0;
    assign o_charge_status_b_o = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // input conditioning
    wire [13:0] raw_in;
    wire [13:0] flt;   // filtered copies of raw_in
    assign raw_in = {i_charge_disable_n, i_main_rails_enable,
                     i_aux_rail_enable, i_input_good, i_bat_below_lowv,
                     i_bat_at_reg, i_bat_below_rch, i_bat_below_uvlo,
                     i_term_current, i_thermal_limit,
                     i_main_low_voltage, i_aux_low_voltage};
    // disable pin resets high so nothing charges before it is seen
    genvar g;
    generate
        for (g = 0; g < 14; g = g + 1) begin : g_in
            lichg_sync_filt #(
                .RST_VAL  ((g == 13) ? 1'b1 : 1'b0)
            ) u_filt (
                .i_ref_clk(i_ref_clk),
                .i_rst_n  (i_rst_n),
                .i_ce     (i_ce),
                .i_async  (raw_in[g]),
                .o_level  (flt[g])
            );
        end
    endgenerate

    wire       dis_n     = flt[13];
    wire       main_en   = flt[12];
    wire       aux_en    = flt[11];
    wire       in_good   = flt[10];
    wire       below_lv  = flt[9];
    wire       at_reg    = flt[8];
    wire       below_rch = flt[7];
    wire       below_uv  = flt[6];
    wire       term_i    = flt[5];
    wire       hot       = flt[4];
    wire [2:0] main_low  = flt[3:1];
    wire       aux_low   = flt[0];

    ////////////////////////////////////////////////////////////////////
    // state registers
    reg  [5:0]  st_q, st_d;
    reg  [31:0] tmr_q, tmr_d;     // safety timer, phase dependent
    reg  [31:0] nb_q, nb_d;       // regulation dwell / deglitch counter
    reg         dis_q;            // previous disable level for edges
    reg         main_en_q;
    reg         aux_en_q;
    reg  [2:0]  main_lat_q;
    reg         aux_lat_q;

    // a disable toggle is a high-to-low return after a high period
    wire dis_fall = dis_q & ~dis_n;
    // charging allowed only with good input and the host enabling it
    wire chg_ok   = ~dis_n & in_good;

    // limit check shared by all counters
    function cnt_done;
        input [31:0] cnt;
        input [31:0] lim;
        begin
            cnt_done = (cnt >= lim - 32'h1);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // next-state logic for the charger
    always @* begin
        st_d  = st_q;
        tmr_d = tmr_q;
        nb_d  = nb_q;
        case (st_q)
            ST_SUSP: begin
                tmr_d = 32'h0;
                if (chg_ok) begin
                    // out of cut-off charging restarts in precondition
                    st_d = (below_lv || below_uv) ? ST_PRE : ST_FAST;
                end
            end
            ST_PRE: begin
                tmr_d = tmr_q + 32'h1;  // keeps counting when hot
                if (!below_lv && !below_uv) begin
                    st_d  = ST_FAST;
                    tmr_d = 32'h0;
                end else if (cnt_done(tmr_q, PRECHG_CYC)) begin
                    st_d = ST_FLT;
                end
            end
            ST_FAST: begin
                tmr_d = tmr_q + 32'h1;
                nb_d  = 32'h0;
                if (cnt_done(tmr_q, CHG_CYC)) begin
                    st_d = ST_FLT;
                end else if (at_reg) begin
                    st_d = ST_VREG;
                end
            end
            ST_VREG: begin
                tmr_d = tmr_q + 32'h1;
                // with no cell the node sits at regulation and no
                // termination current shows: give up after dwell
                nb_d  = nb_q + 32'h1;
                if (term_i || cnt_done(nb_q, TRMDET_CYC)) begin
                    st_d = ST_DONE;
                    nb_d = 32'h0;
                end else if (cnt_done(tmr_q, CHG_CYC)) begin
                    st_d = ST_FLT;
                end
            end
            ST_DONE: begin
                // deglitch the recharge crossing before restarting
                nb_d = below_rch ? nb_q + 32'h1 : 32'h0;
                if (below_rch && cnt_done(nb_q, DEGL_CYC)) begin
                    st_d  = ST_PRE;
                    tmr_d = 32'h0;
                    nb_d  = 32'h0;
                end
            end
            ST_FLT: begin
                // held while above recharge; fresh cycle once below,
                // but a low start first waits for a rise
                if (below_rch && nb_q[0]) begin
                    st_d  = ST_PRE;
                    tmr_d = 32'h0;
                    nb_d  = 32'h0;
                end else if (!below_rch) begin
                    nb_d = 32'h1;  // seen above threshold
                end
            end
            default: begin
                st_d = ST_SUSP;
            end
        endcase
        // disable pin wins over every state and clears faults
        if (dis_n || !in_good) begin
            st_d = ST_SUSP;
            nb_d = 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // charger registers; thermal shutdown gates outputs, not timers
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q  <= ST_SUSP;  // power-on reset clears the fault
            tmr_q <= 32'h0;
            nb_q  <= 32'h0;
            dis_q <= 1'b1;
        end else if (i_ce) begin
            st_q  <= st_d;
            tmr_q <= tmr_d;
            nb_q  <= nb_d;
            dis_q <= dis_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // low-voltage latches; the enable clear has priority over the set
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            main_en_q  <= 1'b0;
            aux_en_q   <= 1'b0;
            main_lat_q <= 3'h0;
            aux_lat_q  <= 1'b0;
        end else if (i_ce) begin
            main_en_q <= main_en;
            aux_en_q  <= aux_en;
            // only a running rail can latch; low on enable clears it
            if (main_en && main_en_q && |main_low) begin
                main_lat_q <= main_lat_q | main_low;
            end else if (!main_en) begin
                main_lat_q <= 3'h0;
            end
            if (aux_en && aux_en_q && aux_low) begin
                aux_lat_q <= 1'b1;
            end else if (!aux_en) begin
                aux_lat_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    reg [1:0] stat_v;
    always @* begin
        case (st_q)
            ST_PRE:  stat_v = `LICHG_STAT_PRE;
            ST_FAST: stat_v = `LICHG_STAT_FAST;
            ST_VREG: stat_v = `LICHG_STAT_FAST;
            ST_DONE: stat_v = `LICHG_STAT_DONE;
            default: stat_v = `LICHG_STAT_OFF;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_charge_status_a_oe  <= 1'b0;
            o_charge_status_b_oe  <= 1'b0;
            o_charger_on          <= 1'b0;
            o_precharge_mode      <= 1'b0;
            o_fault_probe_current <= 1'b0;
            o_battery_path_on     <= 1'b0;
            o_power_paths_on      <= 1'b0;
            o_main_rails_on       <= 1'b0;
            o_main_rail_latched   <= 3'h0;
            o_aux_rail_on         <= 1'b0;
            o_charge_state        <= ST_SUSP;
        end else if (i_ce) begin
            // pins released in suspend, fault and shutdown
            o_charge_status_a_oe <= stat_v[1] & ~hot;
            o_charge_status_b_oe <= stat_v[0] & ~hot;
            o_charger_on <= ~hot &
                (st_q == ST_PRE || st_q == ST_FAST ||
                 st_q == ST_VREG);
            o_precharge_mode <= (st_q == ST_PRE);
            // probe current only while faulted and still below
            o_fault_probe_current <= ~hot & (st_q == ST_FLT) &
                                     below_rch & ~nb_q[0];
            o_battery_path_on <= ~hot & ~below_uv;
            o_power_paths_on  <= ~hot;
            o_main_rails_on   <= ~hot & main_en & ~|main_lat_q;
            o_main_rail_latched <= main_lat_q;
            o_aux_rail_on     <= ~hot & aux_en & ~aux_lat_q;
            o_charge_state    <= st_q;
        end
    end
endmodule

/* lichg_ctrl_monitor.sv */
// checker for charge control outputs against their causes
`timescale 1ns/1ps
module lichg_mon (
    // clock and reset
    input wire       i_ref_clk,
    input wire       i_rst_n,
    // watched inputs
    input wire       i_charge_disable_n,
    input wire       i_bat_below_uvlo,
    input wire       i_thermal_limit,
    // watched outputs
    input wire       o_charge_status_a_oe,
    input wire       o_charge_status_b_oe,
    input wire       o_charger_on,
    input wire       o_fault_probe_current,
    input wire       o_battery_path_on,
    input wire       o_power_paths_on,
    input wire       o_main_rails_on,
    input wire [2:0] o_main_rail_latched,
    input wire       o_aux_rail_on,
    input wire [5:0] o_charge_state
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////
    // run lengths of raw levels; 15 lies well past the 8-edge latency
    reg [3:0] dis_q, thm_q, calm_q, uv_q;
    function [3:0] inc(input [3:0] c);
        inc = (c == 4'hf) ? c : c + 4'h1;
    endfunction
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dis_q  <= 4'h0;
            thm_q  <= 4'h0;
            calm_q <= 4'h0;
            uv_q   <= 4'h0;
        end else begin
            dis_q  <= i_charge_disable_n ? inc(dis_q) : 4'h0;
            thm_q  <= i_thermal_limit ? inc(thm_q) : 4'h0;
            calm_q <= i_thermal_limit ? 4'h0 : inc(calm_q);
            uv_q   <= i_bat_below_uvlo ? inc(uv_q) : 4'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // status pins follow a state that held for two samples
    property p_stat(s, a, b);
        (calm_q == 4'hf && $stable(o_charge_state) && s) |->
            (o_charge_status_a_oe == a && o_charge_status_b_oe == b);
    endproperty
    AST_STAT_PRE: assert property (p_stat(o_charge_state == 6'h01, 1, 1))
        else $error("status wrong in precharge");
    AST_STAT_FAST: assert property (p_stat(o_charge_state == 6'h02 ||
        o_charge_state == 6'h04, 1, 0)) else $error("status wrong in fast");
    AST_STAT_DONE: assert property (p_stat(o_charge_state == 6'h08, 0, 1))
        else $error("status wrong in done");
    AST_STAT_OFF: assert property (p_stat(o_charge_state == 6'h10 ||
        o_charge_state == 6'h20, 0, 0)) else $error("status not released");
    AST_HALT: assert property (dis_q == 4'hf |->
        o_charge_state == 6'h10 && !o_charger_on) else $error("not halted");
    AST_THERM: assert property (thm_q == 4'hf |-> !(o_charger_on ||
        o_power_paths_on || o_main_rails_on || o_aux_rail_on))
        else $error("output on in thermal shutdown");
    AST_PROBE: assert property (o_fault_probe_current |->
        o_charge_state == 6'h20 || $past(o_charge_state) == 6'h20)
        else $error("probe current outside fault");
    AST_UVPATH: assert property (uv_q == 4'hf |-> !o_battery_path_on)
        else $error("battery path closed in undervoltage");
    AST_UVPRE: assert property (uv_q == 4'hf && $past(o_charge_state) ==
        6'h10 && o_charge_state != 6'h10 |-> o_charge_state == 6'h01)
        else $error("undervoltage start not precharge");
    AST_LATCH: assert property ($past(o_main_rail_latched) != 3'h0 &&
        o_main_rail_latched != 3'h0 |-> !o_main_rails_on)
        else $error("main group on while latched");
    AST_IDLE: assert property ($stable(o_charge_state) &&
        o_charge_state inside {6'h08, 6'h10, 6'h20} |-> !o_charger_on)
        else $error("charger on while idle");
    AST_ONEHOT: assert property ($onehot(o_charge_state))
        else $error("state not one-hot");
    // main scenarios reached
    C_PRE: cover property (o_charge_state == 6'h01);
    C_DONE: cover property (o_charge_state == 6'h08);
    C_FAULT: cover property (o_fault_probe_current);
endmodule
bind lichg_ctrl lichg_mon u_mon (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_charge_disable_n(i_charge_disable_n),
    .i_bat_below_uvlo(i_bat_below_uvlo), .i_thermal_limit(i_thermal_limit),
    .o_charge_status_a_oe(o_charge_status_a_oe),
    .o_charge_status_b_oe(o_charge_status_b_oe), .o_charger_on(o_charger_on),
    .o_fault_probe_current(o_fault_probe_current),
    .o_battery_path_on(o_battery_path_on),
    .o_power_paths_on(o_power_paths_on), .o_main_rails_on(o_main_rails_on),
    .o_main_rail_latched(o_main_rail_latched), .o_aux_rail_on(o_aux_rail_on),
    .o_charge_state(o_charge_state));

/* lichg_host.sv */
// host processor model: drives the enables, reads the status pins
`timescale 1ns/1ps
module lichg_host (
    // clock
    input  wire       i_ref_clk,
    // open-drain status pins of the device
    input  wire       i_stat_a_o,
    input  wire       i_stat_a_oe,
    input  wire       i_stat_b_o,
    input  wire       i_stat_b_oe,
    // enables to the device
    output reg        o_charge_disable_n,
    output reg        o_main_rails_enable,
    output reg        o_aux_rail_enable,
    // pin levels as the host sees them
    output wire [1:0] o_pins
);
    // board pull-ups hold a released pin high
    assign o_pins = {i_stat_a_oe ? i_stat_a_o : 1'b1,
                     i_stat_b_oe ? i_stat_b_o : 1'b1};
    initial begin
        o_charge_disable_n  = 1'b1;
        o_main_rails_enable = 1'b1;
        o_aux_rail_enable   = 1'b1;
    end
    // set one enable just after a rising edge (0 charge, 1 main, 2 aux)
    task drive(input integer w, input v);
        begin
            @(posedge i_ref_clk);
            #1;
            case (w)
                0: o_charge_disable_n = v;
                1: o_main_rails_enable = v;
                default: o_aux_rail_enable = v;
            endcase
        end
    endtask
    // pulse long enough to pass the input filter, then restore
    task toggle(input integer w, input v);
        begin
            drive(w, v);
            repeat (20) @(posedge i_ref_clk);
            drive(w, ~v);
        end
    endtask
endmodule

/* test_li_ion_charge_control_fsm.sv */
// testbench for the charge control block
`timescale 1ns/1ps
module test_li_ion_charge_control_fsm;
    reg clk, rst_n, lowv, at_reg, rch, uv, term, therm, aux_lv, good;
    wire pre_m;
    reg [2:0] main_lv;
    reg [11:0] rows [0:4];
    wire dis_n, men, aen, sa_o, sa_oe, sb_o, sb_oe, chg_on, probe;
    wire bat_on, pp_on, main_on, aux_on;
    wire [1:0] pins;
    wire [2:0] latched;
    wire [5:0] st;
    integer errors, num_checks, i;
    // short timers keep the run brief
    lichg_ctrl #(.TRMDET_CYC(200), .DEGL_CYC(50), .PRECHG_CYC(300),
        .CHG_CYC(400)) uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .i_charge_disable_n(dis_n), .i_main_rails_enable(men),
        .i_aux_rail_enable(aen), .i_input_good(good),
        .i_bat_below_lowv(lowv), .i_bat_at_reg(at_reg),
        .i_bat_below_rch(rch), .i_bat_below_uvlo(uv),
        .i_term_current(term), .i_thermal_limit(therm),
        .i_main_low_voltage(main_lv), .i_aux_low_voltage(aux_lv),
        .o_charge_status_a_o(sa_o), .o_charge_status_a_oe(sa_oe),
        .o_charge_status_b_o(sb_o), .o_charge_status_b_oe(sb_oe),
        .o_charger_on(chg_on), .o_precharge_mode(pre_m),
        .o_fault_probe_current(probe), .o_battery_path_on(bat_on),
        .o_power_paths_on(pp_on), .o_main_rails_on(main_on),
        .o_main_rail_latched(latched), .o_aux_rail_on(aux_on),
        .o_charge_state(st));
    lichg_host host (.i_ref_clk(clk), .i_stat_a_o(sa_o), .i_stat_a_oe(sa_oe),
        .i_stat_b_o(sb_o), .i_stat_b_oe(sb_oe), .o_charge_disable_n(dis_n),
        .o_main_rails_enable(men), .o_aux_rail_enable(aen), .o_pins(pins));
    ////////////////////////////////////////////////////////////////////////
    task chk_st(input string n, input [5:0] e, input [5:0] g);
        begin
            num_checks++;
            if (g !== e) begin
                errors++;
                $display("BAD %s exp %h got %h", n, e, g);
            end
        end
    endtask
    task chk_fl(input string n, input [2:0] e, input [2:0] g);
        begin
            num_checks++;
            if (g !== e) begin
                errors++;
                $display("BAD %s exp %b got %b", n, e, g);
            end
        end
    endtask
    // wait cycles, land just after an edge for the next drive
    task waitc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d errors %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog: the run needs about 1,900 cycles
    initial begin
        #60000;
        errors++;
        wrap_up;
    end
    initial begin
        // rows: {lowv, at_reg, rch, term}, state, {status_a, status_b}
        rows[0] = 12'ha07;
        rows[1] = 12'h20a;
        rows[2] = 12'h412;
        rows[3] = 12'h521;
        rows[4] = 12'ha07;
        {rst_n, lowv, at_reg, rch, uv, term, therm, aux_lv} = 8'h00;
        main_lv = 3'h0;
        good = 1'b1;
        errors = 0;
        num_checks = 0;
        waitc(6);
        rst_n = 1'b1;
        waitc(20);
        chk_st("reset state", 6'h10, st);
        chk_fl("reset pins", 3'h3, {1'b0, pins});
        host.drive(0, 1'b0);
        for (i = 0; i < 5; i++) begin
            {lowv, at_reg, rch, term} = rows[i][11:8];
            waitc(80);
            chk_st("row state", rows[i][7:2], st);
            chk_fl("row pins", {1'b0, ~rows[i][1:0]}, {1'b0, pins});
        end
        // precharge timer runs out with the battery below recharge
        waitc(320);
        chk_st("fault", 6'h20, st);
        chk_fl("probe on", 3'h7, {probe, pins});
        rch = 1'b0;
        waitc(80);
        chk_st("fault held", 6'h20, st);
        chk_fl("probe off", 3'h3, {probe, pins});
        rch = 1'b1;
        waitc(80);
        chk_st("fault cleared", 6'h01, st);
        waitc(320);
        chk_st("fault again", 6'h20, st);
        host.toggle(0, 1'b1);
        waitc(40);
        chk_st("toggle clears", 6'h01, st);
        therm = 1'b1;
        waitc(30);
        chk_fl("thermal off", 3'h0, {chg_on | aux_on, pp_on, main_on});
        therm = 1'b0;
        waitc(30);
        chk_st("after thermal", 6'h01, st);
        chk_fl("resumed", 3'h7, {chg_on, main_on, aux_on});
        waitc(230);
        chk_st("timer kept", 6'h20, st);
        host.drive(0, 1'b1);
        waitc(30);
        chk_st("halted", 6'h10, st);
        chk_fl("halted out", 3'h3, {chg_on, pins});
        {uv, lowv} = 2'b10;
        waitc(30);
        chk_fl("uv path", 3'h0, {2'b00, bat_on});
        host.drive(0, 1'b0);
        waitc(30);
        chk_st("uv restart", 6'h01, st);
        chk_fl("uv pre mode", 3'h1, {2'b00, pre_m});
        uv = 1'b0;
        waitc(30);
        chk_st("uv exit", 6'h02, st);
        main_lv = 3'h2;
        waitc(20);
        chk_fl("main latch", 3'h2, latched);
        main_lv = 3'h0;
        waitc(20);
        chk_fl("main held", 3'h0, {2'b00, main_on});
        host.toggle(1, 1'b0);
        waitc(30);
        chk_fl("main back", 3'h1, {latched[1], 1'b0, main_on});
        aux_lv = 1'b1;
        waitc(20);
        aux_lv = 1'b0;
        waitc(20);
        chk_fl("aux held", 3'h0, {2'b00, aux_on});
        host.toggle(2, 1'b0);
        waitc(30);
        chk_fl("aux back", 3'h1, {2'b00, aux_on});
        // losing the supply drops the charger to suspend
        good = 1'b0;
        waitc(30);
        chk_st("no input", 6'h10, st);
        wrap_up;
    end
endmodule
